/* rtl/octal_dac_serial_loader.v */
// serial command loader with double-buffered codes for eight converters
//
// What this block does
// - shift data on serial clock fall, latch high
// - command word is twelve bits long
// - bits arrive most significant first
// - latch strobe fall copies word to holding
// - update and software hold low: selected output follows immediately
// - update high freezes outputs until its fall
// - update pulse moves all holding latches together
// - select bits index channels zero to seven
// - range bit stored per channel with code
// - reset clears every channel code to zero
// - each channel presents unsigned code and range
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "octal_dac_regs.vh"
module octal_dac_serial_loader (
	// clock and reset
	input  wire                          pclk,
	input  wire                          presetn,
	// apb slave
	input  wire                          psel,
	input  wire                          penable,
	input  wire                          pwrite,
	input  wire [`ADDR_BITS-1:0]         paddr,
	input  wire [31:0]                   pwdata,
	output wire                          pready,
	output reg  [31:0]                   prdata,
	output reg                           pslverr,
	// three-wire serial pins plus the update strobe, all asynchronous
	input  wire                          ser_clk,
	input  wire                          ser_data,
	input  wire                          word_latch_strobe,
	input  wire                          dac_update_strobe,
	// per-channel code and range for the converters, channel 0 in low bits
	output wire [`NUM_CHAN*`CODE_BITS-1:0] dac_code,
	output wire [`NUM_CHAN-1:0]          dac_range
);

	// synchronised pins
	wire [`PIN_BITS-1:0] pin_s;       // second-stage copies
	reg  [`PIN_BITS-1:0] pin_prev_q;  // one cycle older, for edges

	// serial register outputs
	wire [`WORD_MSB:0]   word;        // last twelve bits shifted in
	wire [`CNT_BITS-1:0] bit_cnt;     // bits since last latch

	// detected events
	wire clk_fall;      // serial clock high to low
	wire latch_fall;    // word latch strobe high to low
	wire upd_fall;      // update strobe high to low
	wire shift_en;      // take a bit this cycle
	wire shift_bit;     // the bit to take
	wire upd_level;     // effective update strobe level
	wire xfer_all;      // move every holding latch to its output
	wire sw_xfer;       // software transfer, allowed only with the pin low

	// decoded word fields
	wire [`SEL_BITS-1:0]  word_sel;
	wire [`CODE_BITS-1:0] word_code;
	wire                  word_range;

	// double-buffer storage, one entry per channel
	reg  [`CODE_BITS-1:0] hold_code_q  [0:`NUM_CHAN-1];
	reg                   hold_range_q [0:`NUM_CHAN-1];
	reg  [`CODE_BITS-1:0] out_code_q   [0:`NUM_CHAN-1];
	reg                   out_range_q  [0:`NUM_CHAN-1];

	// software view
	reg                   sw_hold_q;   // blocks immediate loads like update high; a software transfer pulse still moves outputs
	reg                   sw_upd_q;    // one-cycle software transfer pulse
	reg                   pending_q;   // holding latches newer than outputs
	reg  [`WORD_MSB:0]    last_word_q; // word captured at the last latch

	// apb decode helpers
	wire                  apb_setup;
	wire                  apb_write;
	wire [`ADDR_BITS-1:0] base_addr;
	wire [`SEL_BITS-1:0]  reg_idx;
	reg  [31:0]           rdata_d;
	reg                   err_d;

	// pin synchroniser: all four pins go through the same two stages so
	// their relative timing is kept
	pin_sync #(
		.WIDTH   (`PIN_BITS)
	) u_pin_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.pin_in  ({dac_update_strobe, word_latch_strobe, ser_data, ser_clk}),
		.pin_out (pin_s)
	);

	// delayed copy of the synchronised pins for edge detection; it clears
	// low like the synchroniser, and since the serial clock and the latch
	// strobe idle high, release shows a rise there, never a fall, so no
	// false shift or latch follows reset
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pin_prev_q <= `PIN_RST;
		else
			pin_prev_q <= pin_s;
	end

	// edge detection reads only second-stage and delayed values
	assign clk_fall   = pin_prev_q[`PIN_CLK]   & ~pin_s[`PIN_CLK];
	assign latch_fall = pin_prev_q[`PIN_LATCH] & ~pin_s[`PIN_LATCH];
	assign upd_fall   = pin_prev_q[`PIN_UPD]   & ~pin_s[`PIN_UPD];

	// shift while latched
	// the data bit is taken from the delayed copy, i.e. sampled while the
	// serial clock was still high; the host only holds data a short time
	// after the falling edge, so the older sample is the safe one
	// a fall with the latch strobe low is dropped, so stray clocks between
	// words leave the serial register alone
	assign shift_en  = clk_fall & pin_prev_q[`PIN_LATCH];
	assign shift_bit = pin_prev_q[`PIN_DATA];

	// burst count is free
	// the shifter has no framing: any number of clocks may arrive before
	// the latch, two bursts of eight included
	serial_shifter u_shifter (
		.pclk     (pclk),
		.presetn  (presetn),
		.shift_en (shift_en),
		.bit_in   (shift_bit),
		.cnt_clr  (latch_fall),
		.word     (word),
		.bit_cnt  (bit_cnt)
	);

	// last twelve bits used
	// select in the top three bits, then range, then code
	assign word_sel   = word[`SEL_MSB:`SEL_LSB];
	assign word_range = word[`RANGE_POS];
	assign word_code  = word[`CODE_MSB:`CODE_LSB];

	// update level freezes
	// the software hold blocks immediate loads like the pin held high, but unlike the pin it does not drop a software transfer pulse
	assign upd_level = pin_s[`PIN_UPD] | sw_hold_q;

	// simultaneous transfer
	// a falling update pin or a software pulse moves every channel; the
	// software pulse is dropped while the update pin is high, because a
	// high pin must freeze every output whatever software asks for
	assign sw_xfer  = sw_upd_q & ~pin_s[`PIN_UPD];
	assign xfer_all = upd_fall | sw_xfer;

	// per-channel double buffer
	// the holding stage is written whatever the update level: that is what
	// lets the host stage all eight channels and move them in one go
	genvar ch;
	generate
		for (ch = 0; ch < `NUM_CHAN; ch = ch + 1)
		begin : g_chan
			wire sel_hit;
			wire hold_load;
			wire [`CODE_BITS-1:0] hold_code_d;
			wire                  hold_range_d;

			assign sel_hit   = (word_sel == ch);
			assign hold_load = latch_fall & sel_hit;

			// next holding values, so a transfer in the same cycle as a
			// latch carries the freshly latched word
			assign hold_code_d  = hold_load ? word_code  : hold_code_q[ch];
			assign hold_range_d = hold_load ? word_range : hold_range_q[ch];

			// holding latch
			// range kept per channel
			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					hold_code_q[ch]  <= `CODE_RST;
					hold_range_q[ch] <= `RANGE_RST;
				end
				else
				begin
					hold_code_q[ch]  <= hold_code_d;
					hold_range_q[ch] <= hold_range_d;
				end
			end

			// output latch
			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					out_code_q[ch]  <= `CODE_RST;
					out_range_q[ch] <= `RANGE_RST;
				end
				else if (xfer_all)
				begin
					out_code_q[ch]  <= hold_code_d;
					out_range_q[ch] <= hold_range_d;
				end
				else if (hold_load && !upd_level)
				begin
					out_code_q[ch]  <= word_code;
					out_range_q[ch] <= word_range;
				end
			end

			// unsigned code presented
			// the converter scales code/256 by one plus the range bit
			assign dac_code[ch*`CODE_BITS +: `CODE_BITS] = out_code_q[ch];
			assign dac_range[ch]                         = out_range_q[ch];
		end
	endgenerate

	// pending flag: set by a latch that did not reach its output, cleared
	// by a transfer; a latch in the same cycle as a transfer is carried by
	// that transfer, so clearing then loses nothing
	// software reads this to know whether a transfer is still owed
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pending_q <= 1'b0;
		else if (xfer_all)
			pending_q <= 1'b0;
		else if (latch_fall && upd_level)
			pending_q <= 1'b1;
	end

	// last latched word for software inspection
	// handy when the host is suspected of sending too few or too many clocks
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			last_word_q <= `WORD_RST;
		else if (latch_fall)
			last_word_q <= word;
	end

	// apb: zero wait states, read data prepared in the setup cycle
	// the registers are flops behind a small mux, so no wait state is needed;
	// a slower register file would need pready from a counter instead
	assign pready    = 1'b1;
	assign apb_setup = psel & ~penable;
	assign apb_write = psel & penable & pwrite;
	assign base_addr = paddr & `OFF_BASE_MASK;
	assign reg_idx   = paddr[`IDX_MSB:`IDX_LSB];

	// control register: hold level and self-clearing transfer pulse
	// hold only blocks immediate loads; the pulse still moves all channels
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sw_hold_q <= 1'b0;
			sw_upd_q  <= 1'b0;
		end
		else if (apb_write && (paddr == `OFF_CTRL))
		begin
			sw_hold_q <= pwdata[`CTRL_HOLD_POS];
			sw_upd_q  <= pwdata[`CTRL_UPD_POS];
		end
		else
		begin
			// the pulse lasts one cycle whatever software wrote
			sw_upd_q  <= 1'b0;
		end
	end

	// read mux and unmapped-address detection
	always @*
	begin
		rdata_d = `DATA_RST;
		err_d   = 1'b0;
		if (paddr[`IDX_LSB-1:0] != {`IDX_LSB{1'b0}})
		begin
			// misaligned access is refused; every register is one aligned
			// word, so a byte or half-word address has no meaning here
			err_d = 1'b1;
		end
		else if (paddr == `OFF_CTRL)
		begin
			rdata_d[`CTRL_HOLD_POS] = sw_hold_q;
		end
		else if (paddr == `OFF_STATUS)
		begin
			if (pwrite)
				err_d = 1'b1;
			rdata_d[`STAT_CNT_MSB:0] = bit_cnt;
			rdata_d[`STAT_UPD_POS]   = pin_s[`PIN_UPD];
			rdata_d[`STAT_LATCH_POS] = pin_s[`PIN_LATCH];
			rdata_d[`STAT_PEND_POS]  = pending_q;
		end
		else if (paddr == `OFF_LAST_WORD)
		begin
			if (pwrite)
				err_d = 1'b1;
			rdata_d[`WORD_MSB:0] = last_word_q;
		end
		else if (base_addr == `OFF_OUT_BASE)
		begin
			if (pwrite)
				err_d = 1'b1;
			rdata_d[`CODE_MSB:0]  = out_code_q[reg_idx];
			rdata_d[`RANGE_POS]   = out_range_q[reg_idx];
		end
		else if (base_addr == `OFF_HOLD_BASE)
		begin
			if (pwrite)
				err_d = 1'b1;
			rdata_d[`CODE_MSB:0]  = hold_code_q[reg_idx];
			rdata_d[`RANGE_POS]   = hold_range_q[reg_idx];
		end
		else
		begin
			// unmapped: zero data and an error answer
			err_d = 1'b1;
		end
	end

	// read data and error registered in the setup cycle, stable in access
	// a write loads zero so prdata never echoes register contents on writes
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= `DATA_RST;
			pslverr <= 1'b0;
		end
		else if (apb_setup)
		begin
			prdata  <= pwrite ? `DATA_RST : rdata_d;
			pslverr <= err_d;
		end
	end

endmodule

/* rtl/octal_dac_regs.vh */
// constants shared by the serial loader files: field layout, offsets, resets
`ifndef OCTAL_DAC_REGS_VH
`define OCTAL_DAC_REGS_VH

// serial command word layout: select bits, range bit, code bits (msb first)
`define WORD_BITS        12
`define WORD_MSB         11
`define CODE_BITS        8
`define CODE_MSB         7
`define CODE_LSB         0
`define RANGE_POS        8
`define SEL_MSB          11
`define SEL_LSB          9
`define SEL_BITS         3
`define NUM_CHAN         8
`define CHAN_BITS        9

// bit counter width and saturation value
`define CNT_BITS         4
`define CNT_MAX          4'h0f

// pin synchroniser bundle: ser_clk, ser_data, word latch, update strobe
`define PIN_BITS         4
`define PIN_CLK          0
`define PIN_DATA         1
`define PIN_LATCH        2
`define PIN_UPD          3

// apb register offsets (byte addresses)
`define ADDR_BITS        12
`define OFF_CTRL         12'h0000
`define OFF_STATUS       12'h0004
`define OFF_LAST_WORD    12'h0008
`define OFF_OUT_BASE     12'h0020
`define OFF_HOLD_BASE    12'h0040
`define OFF_BASE_MASK    12'h0fe0
`define IDX_MSB          4
`define IDX_LSB          2

// control register fields
`define CTRL_HOLD_POS    0
`define CTRL_UPD_POS     1

// status register fields
`define STAT_CNT_MSB     3
`define STAT_UPD_POS     4
`define STAT_LATCH_POS   5
`define STAT_PEND_POS    6

// reset values
`define CODE_RST         8'h00
`define RANGE_RST        1'b0
`define WORD_RST         12'h000
`define CNT_RST          4'h0
`define PIN_RST          4'h0
`define DATA_RST         32'h0000_0000

`endif

/* rtl/pin_sync.v */
// two-flop synchroniser for a bundle of asynchronous input pins
`timescale 1ns/10ps
`include "octal_dac_regs.vh"
module pin_sync #(
	parameter WIDTH = `PIN_BITS
)(
	// clock and reset
	input  wire             pclk,
	input  wire             presetn,
	// raw pins and synchronised copy
	input  wire [WIDTH-1:0] pin_in,
	output wire [WIDTH-1:0] pin_out
);

	reg [WIDTH-1:0] meta_q;  // first stage, read only by the second
	reg [WIDTH-1:0] sync_q;  // second stage, safe for logic

	// both stages clear to zero; pins are trusted only after two edges
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_q <= {WIDTH{1'b0}};
			sync_q <= {WIDTH{1'b0}};
		end
		else
		begin
			meta_q <= pin_in;
			sync_q <= meta_q;
		end
	end

	assign pin_out = sync_q;

endmodule

/* rtl/serial_shifter.v */
// 12-bit msb-first serial input register with a saturating bit counter
`timescale 1ns/10ps
`include "octal_dac_regs.vh"
module serial_shifter (
	// clock and reset
	input  wire                  pclk,
	input  wire                  presetn,
	// shift request and new bit
	input  wire                  shift_en,
	input  wire                  bit_in,
	// counter restart after a word latch
	input  wire                  cnt_clr,
	// assembled word and bits seen
	output wire [`WORD_MSB:0]    word,
	output wire [`CNT_BITS-1:0]  bit_cnt
);

	reg [`WORD_MSB:0]   word_q;  // serial input register
	reg [`CNT_BITS-1:0] cnt_q;   // bits since last latch

	// shift left so the first bit ends up in the top position; older bits
	// fall off the top, so only the last twelve count
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			word_q <= `WORD_RST;
		else if (shift_en)
			word_q <= {word_q[`WORD_MSB-1:0], bit_in};
	end

	// counter saturates so long bursts still read as "more than enough"
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_q <= `CNT_RST;
		else if (shift_en)
		begin
			// a bit and a clear in one cycle: the bit wins and is counted
			if (cnt_q != `CNT_MAX)
				cnt_q <= cnt_q + 1'b1;
		end
		else if (cnt_clr)
			cnt_q <= `CNT_RST;
	end

	assign word    = word_q;
	assign bit_cnt = cnt_q;

endmodule

/* tb/host_model.sv */
// host side model driving the three-wire serial bus and the update strobe
`timescale 1ns/10ps
module host_model (
	// bench clock paces the link, one link period is eight cycles
	input  wire logic pclk,
	// serial pins toward the loader
	output logic      ser_clk,
	output logic      ser_data,
	output logic      word_latch_strobe,
	output logic      dac_update_strobe
);
	// latch strobe idles high
	// link clock parked high so the first move is a fall
	initial
	begin
		ser_clk = 1'b1;
		ser_data = 1'b0;
		word_latch_strobe = 1'b1;
		dac_update_strobe = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic send(input logic [15:0] w, input int n);
		for (int i = n - 1; i >= 0; i--)
		begin
			ser_data <= w[i];
			wt(4);
			ser_clk <= 1'b0;
			wt(2);
			// past the valid time the line no longer shows the bit
			ser_data <= ~w[i];
			wt(2);
			ser_clk <= 1'b1;
		end
	endtask
	task automatic latch();
		word_latch_strobe <= 1'b0;
		wt(6);
		word_latch_strobe <= 1'b1;
		wt(8);
	endtask
	// update level, held long enough for the synchroniser
	task automatic set_upd(input logic v);
		dac_update_strobe <= v;
		wt(6);
	endtask
endmodule

/* tb/loader_properties.sv */
// port assertions for the serial loader
`timescale 1ns/10ps
module loader_props (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// strobes and converter outputs
	input wire logic        word_latch_strobe,
	input wire logic        dac_update_strobe,
	input wire logic [63:0] dac_code,
	input wire logic [7:0]  dac_range
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic [2:0] quiet_q;  // cycles since a strobe or select edge
	logic       lat_q;    // last seen latch strobe
	logic       upd_q;    // last seen update strobe
	logic       sel_q;    // last seen select
	// pins pass two flops, so seven quiet cycles leave margin
	always @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			quiet_q <= 3'h0;
			lat_q <= 1'b0;
			upd_q <= 1'b0;
			sel_q <= 1'b0;
		end
		else
		begin
			if (lat_q != word_latch_strobe || upd_q != dac_update_strobe || sel_q != psel)
				quiet_q <= 3'h0;
			else if (quiet_q != 3'h7)
				quiet_q <= quiet_q + 3'h1;
			lat_q <= word_latch_strobe;
			upd_q <= dac_update_strobe;
			sel_q <= psel;
		end
	chk_ready_high: assert property (pready)
		else $error("pready low");
	chk_reset_clear: assert property ($rose(presetn) |->
		dac_code == 64'h0 && dac_range == 8'h0) else $error("codes not cleared");
	chk_update_freeze: assert property (dac_update_strobe [*6] |->
		$stable(dac_code) && $stable(dac_range)) else $error("output moved");
	chk_quiet_hold: assert property (quiet_q == 3'h7 |->
		$stable(dac_code) && $stable(dac_range)) else $error("output moved idle");
	chk_err_misaligned: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("misaligned accepted");
	chk_err_unmapped: assert property (psel && penable && paddr >= 12'h060 |-> pslverr)
		else $error("unmapped accepted");
	chk_err_readonly: assert property (psel && penable && pwrite && paddr[1:0] == 2'h0
		&& paddr != 12'h000 |-> pslverr) else $error("read-only written");
	chk_ctrl_ok: assert property (psel && penable && paddr == 12'h000 |-> !pslverr)
		else $error("control refused");
	chk_status_upper: assert property (psel && penable && !pwrite && paddr == 12'h004
		|-> prdata[31:7] == 25'h0) else $error("status upper bits set");
	cover property ($fell(word_latch_strobe) && !dac_update_strobe);
	cover property ($fell(dac_update_strobe));
	cover property (pslverr && penable);
endmodule
bind octal_dac_serial_loader loader_props chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .word_latch_strobe(word_latch_strobe),
	.dac_update_strobe(dac_update_strobe), .dac_code(dac_code), .dac_range(dac_range));

/* tb/tb_octal_dac_serial_loader.sv */
// self-checking bench for the serial loader
`timescale 1ns/10ps
`include "octal_dac_regs.vh"
module tb_octal_dac_serial_loader;
	logic        pclk, presetn, psel, penable, pwrite;  // bus master
	logic [11:0] paddr;
	logic [31:0] pwdata;
	wire         pready, pslverr, ser_clk, ser_data, word_latch_strobe, dac_update_strobe;
	wire  [31:0] prdata;
	wire  [63:0] dac_code;
	wire  [7:0]  dac_range;
	logic [8:0]  ev_out [8];   // expected output latches
	logic [8:0]  ev_hold [8];  // expected holding latches
	logic [31:0] rd_d;
	logic        rd_e;
	int          miscompares, samples_checked;
	octal_dac_serial_loader dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .ser_clk(ser_clk),
		.ser_data(ser_data), .word_latch_strobe(word_latch_strobe),
		.dac_update_strobe(dac_update_strobe), .dac_code(dac_code), .dac_range(dac_range));
	host_model host (.pclk(pclk), .ser_clk(ser_clk), .ser_data(ser_data),
		.word_latch_strobe(word_latch_strobe), .dac_update_strobe(dac_update_strobe));
	initial
		pclk = 1'b0;
	always #25 pclk = ~pclk;
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// one apb transfer; waits for pready under a bound
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1)
		begin
			miscompares++;
			$display("[ERR] %0t pready timeout", $time);
			finish_test();
		end
		rd_d = prdata;
		rd_e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic e);
		apb(1'b0, a, 32'h0);
		cmp({31'h0, rd_e}, {31'h0, e}, "read error flag");
		if (!e)
			cmp(rd_d, exp, "read data");
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
		apb(1'b1, a, d);
		cmp({31'h0, rd_e}, {31'h0, e}, "write error flag");
	endtask
	// every channel through both latch views and the ports
	task automatic chk_all();
		for (int i = 0; i < 8; i++)
		begin
			rd(`OFF_OUT_BASE + 12'(4 * i), {23'h0, ev_out[i]}, 1'b0);
			rd(`OFF_HOLD_BASE + 12'(4 * i), {23'h0, ev_hold[i]}, 1'b0);
			cmp({23'h0, dac_range[i], dac_code[8 * i +: 8]}, {23'h0, ev_out[i]}, "port");
		end
	endtask
	// shift a word with optional leading junk, then latch it
	task automatic load(input logic [2:0] s, input logic r, input logic [7:0] c,
		input int lead, input logic live);
		host.send({4'ha, s, r, c}, 12 + lead);
		host.latch();
		ev_hold[s] = {r, c};
		if (live)
			ev_out[s] = {r, c};
	endtask
	task automatic copy_all();
		for (int i = 0; i < 8; i++)
			ev_out[i] = ev_hold[i];
	endtask
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		miscompares = 0;
		samples_checked = 0;
		for (int i = 0; i < 8; i++)
			ev_hold[i] = 9'h000;
		copy_all();
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		chk_all();
		$display("test reset done");
		load(3'h5, 1'b1, 8'ha5, 0, 1'b1);
		chk_all();
		$display("test direct load done");
		host.set_upd(1'b1);
		for (int i = 0; i < 8; i++)
			load(3'(i), i[0], 8'(8'h13 * i + 8'h0c), 0, 1'b0);
		chk_all();
		host.set_upd(1'b0);
		copy_all();
		chk_all();
		$display("test staged update done");
		host.send(16'h0000, 5);
		rd(`OFF_STATUS, 32'h0000_0025, 1'b0);
		load(3'h2, 1'b0, 8'hff, 4, 1'b1);
		chk_all();
		$display("test long frame done");
		wr(`OFF_CTRL, 32'h1, 1'b0);
		load(3'h7, 1'b1, 8'h80, 0, 1'b0);
		rd(`OFF_LAST_WORD, 32'h0000_0f80, 1'b0);
		rd(`OFF_STATUS, 32'h0000_0060, 1'b0);
		chk_all();
		wr(`OFF_CTRL, 32'h2, 1'b0);
		repeat (2) @(posedge pclk);
		copy_all();
		chk_all();
		rd(`OFF_CTRL, 32'h0, 1'b0);
		rd(12'h002, 32'h0, 1'b1);
		rd(12'h100, 32'h0, 1'b1);
		wr(`OFF_STATUS, 32'h1, 1'b1);
		wr(`OFF_OUT_BASE, 32'h1, 1'b1);
		$display("test bus done");
		finish_test();
	end
	// watchdog against a hung sequence
	initial
	begin
		repeat (50000) @(posedge pclk);
		miscompares++;
		$display("[ERR] %0t watchdog expired", $time);
		finish_test();
	end
endmodule
